// ---- hw/hexasc_top.sv ----
// Hex-to-ASCII conversion engine with Avalon-MM register access
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module hexasc_top #(
   parameter int DEST_WORDS = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Status
   output logic error_flag_out,
   output logic busy_out
);
   // ==========================================================
   // Registers and state
   logic [15:0] src_q;
   hexasc_pkg::hexasc_ctl_t ctl_q;
   hexasc_pkg::hexasc_ctl_t run_ctl_q;
   logic [15:0] run_src_q;
   logic [15:0] dst_q [DEST_WORDS];
   logic [15:0] shd_q [DEST_WORDS];
   hexasc_pkg::hexasc_state_t state_q;
   logic [1:0] digit_q;
   logic [2:0] left_q;
   logic [$clog2(DEST_WORDS*2)-1:0] pos_q;
   logic err_q;
   logic bad_ctl_q;
   logic rd_ack_q;
   logic [31:0] readdata_q;
   logic go;
   logic [3:0] cur_digit;
   logic [7:0] cur_char;
   logic ctl_bad;
   logic wr_take;

   // ==========================================================
   // Bus handshake
   // Reads take one wait cycle so read data come from a flip-flop
   // Writes stall while a conversion is in flight
   assign wr_take = avs_write && (state_q == hexasc_pkg::HX_IDLE);
   assign avs_waitrequest = (avs_read && !rd_ack_q) ||
                            (avs_write && state_q != hexasc_pkg::HX_IDLE);
   assign avs_readdata = readdata_q;
   assign go = wr_take && avs_address == hexasc_pkg::OFS_CMD &&
               avs_writedata[hexasc_pkg::CMD_GO_BIT];
   assign error_flag_out = err_q;
   assign busy_out = state_q != hexasc_pkg::HX_IDLE;

   // Out-of-range control fields
   assign ctl_bad = ctl_q.src_digit > hexasc_pkg::MAX_DIGIT ||
                    ctl_q.count > hexasc_pkg::MAX_COUNT ||
                    ctl_q.dst_byte > hexasc_pkg::MAX_DST_BYTE ||
                    ctl_q.parity > hexasc_pkg::PAR_ODD;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_ack_q <= 1'b0;
      end else begin
         rd_ack_q <= avs_read && !rd_ack_q;
      end
   end

   // ==========================================================
   // Read data
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         readdata_q <= 32'h0000_0000;
      end else if (avs_read && !rd_ack_q) begin
         readdata_q <= 32'h0000_0000;
         case (avs_address)
            hexasc_pkg::OFS_STATUS: begin
               readdata_q[hexasc_pkg::STS_BUSY_BIT] <= busy_out;
               readdata_q[hexasc_pkg::STS_ERR_BIT] <= err_q;
            end
            hexasc_pkg::OFS_SRC: readdata_q[15:0] <= src_q;
            hexasc_pkg::OFS_CTL: readdata_q[15:0] <= ctl_q;
            default: begin
               for (int i = 0; i < DEST_WORDS; i++) begin
                  if (avs_address == hexasc_pkg::OFS_DST0 + 8'(4 * i)) begin
                     readdata_q[15:0] <= dst_q[i];
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Operand registers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         src_q <= hexasc_pkg::RST_WORD;
         ctl_q <= hexasc_pkg::RST_WORD;
      end else if (wr_take) begin
         if (avs_address == hexasc_pkg::OFS_SRC) begin
            src_q <= avs_writedata[15:0];
         end
         if (avs_address == hexasc_pkg::OFS_CTL) begin
            ctl_q <= avs_writedata[15:0];
         end
      end
   end

   // ==========================================================
   // Conversion sequencer
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= hexasc_pkg::HX_IDLE;
         run_ctl_q <= hexasc_pkg::RST_WORD;
         run_src_q <= hexasc_pkg::RST_WORD;
         digit_q <= 2'h0;
         left_q <= 3'h0;
         pos_q <= '0;
         bad_ctl_q <= 1'b0;
      end else begin
         case (state_q)
            hexasc_pkg::HX_IDLE: begin
               if (go) begin
                  run_ctl_q <= ctl_q;
                  run_src_q <= src_q;
                  bad_ctl_q <= ctl_bad;
                  digit_q <= ctl_q.src_digit[1:0];
                  left_q <= {1'b0, ctl_q.count[1:0]} + 3'h1;
                  pos_q <= ctl_q.dst_byte[$bits(pos_q)-1:0];
                  state_q <= ctl_bad ? hexasc_pkg::HX_DONE : hexasc_pkg::HX_RUN;
               end
            end
            hexasc_pkg::HX_RUN: begin
               digit_q <= digit_q + 2'h1;
               pos_q <= pos_q + 1'b1;
               left_q <= left_q - 3'h1;
               if (left_q == 3'h1 || pos_q == $bits(pos_q)'(DEST_WORDS * 2 - 1)) begin
                  state_q <= hexasc_pkg::HX_DONE;
               end
            end
            hexasc_pkg::HX_DONE: state_q <= hexasc_pkg::HX_IDLE;
            default: state_q <= hexasc_pkg::HX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Digit select and encode
   assign cur_digit = run_src_q[{digit_q, 2'b00} +: 4];

   hexasc_char_enc u_enc (
      .digit(cur_digit),
      .parity(run_ctl_q.parity),
      .char_out(cur_char)
   );

   // ==========================================================
   // Shadow destination: built during the run, committed at the end
   generate
      for (genvar w = 0; w < DEST_WORDS; w++) begin : g_word
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               shd_q[w] <= hexasc_pkg::RST_WORD;
               dst_q[w] <= hexasc_pkg::RST_WORD;
            end else begin
               if (state_q == hexasc_pkg::HX_IDLE) begin
                  shd_q[w] <= dst_q[w];
               end else if (state_q == hexasc_pkg::HX_RUN &&
                            pos_q[$bits(pos_q)-1:1] == ($bits(pos_q)-1)'(w)) begin
                  if (pos_q[0]) begin
                     shd_q[w][15:8] <= cur_char;
                  end else begin
                     shd_q[w][7:0] <= cur_char;
                  end
               end
               if (state_q == hexasc_pkg::HX_DONE && !bad_ctl_q) begin
                  dst_q[w] <= shd_q[w];
               end else if (wr_take && avs_address == hexasc_pkg::OFS_DST0 + 8'(4 * w)) begin
                  dst_q[w] <= avs_writedata[15:0];
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Error flag: updated with the destination at completion
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         err_q <= 1'b0;
      end else if (state_q == hexasc_pkg::HX_DONE) begin
         err_q <= bad_ctl_q;
      end
   end
endmodule

// ---- hw/hexasc_pkg.sv ----
// Package and per-digit character encoder for the hex-to-ASCII converter
// What this block does
// - Each selected hex digit becomes an ASCII byte
// - Source word holds digits 0..3, low first
// - Digits advance upward, wrapping from 3 to 0
// - Bytes fill low then high, then next word
// - Unwritten destination bytes keep old contents
// - Error flag set on bad control, else cleared
// - Parity mode from control bits 15..12 sets bit 7
// - Mode 0 forces bit 7 to zero
// - Mode 1 gives even count of ones
// - Mode 2 gives odd count of ones
// - 0-9 map to 30-39, A-F to 41-46
// - Control 0121: no parity, high byte, three digits, digit 1
`timescale 1ns/1ps
package hexasc_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SRC = 8'h08;
   localparam logic [7:0] OFS_CTL = 8'h0C;
   localparam logic [7:0] OFS_DST0 = 8'h10;
   // ==========================================================
   // Field positions and reset values
   localparam int CMD_GO_BIT = 0;
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_ERR_BIT = 1;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam int PARITY_MSB = 15;
   localparam int PARITY_LSB = 12;
   // ==========================================================
   // Control word ranges and parity modes
   localparam logic [3:0] MAX_DIGIT = 4'h3;
   localparam logic [3:0] MAX_COUNT = 4'h3;
   localparam logic [3:0] MAX_DST_BYTE = 4'h1;
   localparam logic [3:0] PAR_NONE = 4'h0;
   localparam logic [3:0] PAR_EVEN = 4'h1;
   localparam logic [3:0] PAR_ODD = 4'h2;
   // ==========================================================
   // Character codes
   localparam logic [6:0] CODE_ZERO = 7'h30;
   localparam logic [6:0] CODE_A = 7'h41;
   localparam logic [3:0] DIGIT_TEN = 4'hA;

   // Control word: parity, start destination byte, digit count - 1, start digit
   typedef struct packed {
      logic [3:0] parity;
      logic [3:0] dst_byte;
      logic [3:0] count;
      logic [3:0] src_digit;
   } hexasc_ctl_t;

   typedef enum {HX_IDLE, HX_RUN, HX_DONE} hexasc_state_t;
endpackage

module hexasc_char_enc (
   // Digit in
   input wire logic [3:0] digit,
   input wire logic [3:0] parity,
   // Character out
   output logic [7:0] char_out
);
   logic [6:0] code;
   logic ones_odd;

   always_comb begin
      if (digit < hexasc_pkg::DIGIT_TEN) begin
         code = hexasc_pkg::CODE_ZERO + {3'h0, digit};
      end else begin
         code = hexasc_pkg::CODE_A + {3'h0, digit - hexasc_pkg::DIGIT_TEN};
      end
      ones_odd = ^code;
      case (parity)
         hexasc_pkg::PAR_EVEN: char_out = {ones_odd, code};
         hexasc_pkg::PAR_ODD: char_out = {~ones_odd, code};
         default: char_out = {1'b0, code};
      endcase
   end
endmodule

// ---- sim/hexasc_monitor.sv ----
// Bus timing and status checks for the hex-to-ASCII converter
`timescale 1ns/1ps
module hexasc_monitor #(
   parameter int DEST_WORDS = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Register bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Status
   input wire logic error_flag_out,
   input wire logic busy_out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic go_w;
   assign go_w = avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_writedata[0];
   sequence s_rd; avs_read && !avs_waitrequest; endsequence
   sequence s_rd_ans; avs_waitrequest ##1 !avs_waitrequest; endsequence
   property p_rd_wait; $rose(avs_read) |-> s_rd_ans; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read answer late");
   property p_busy; $rose(busy_out) |-> ##[1:6] !busy_out; endproperty
   a_busy: assert property (p_busy) else $error("conversion too long");
   property p_stall; busy_out && avs_write |-> avs_waitrequest; endproperty
   a_stall: assert property (p_stall) else $error("write taken while busy");
   property p_idle; !busy_out && avs_write |-> !avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("idle write stalled");
   property p_err; $changed(error_flag_out) |-> $past(busy_out) || $past(go_w); endproperty
   a_err: assert property (p_err) else $error("error moved without conversion");
   property p_hi; s_rd |-> avs_readdata[31:16] == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("upper read half set");
   property p_cmd; s_rd ##0 avs_address == 8'h00 |-> avs_readdata == 32'h00000000; endproperty
   a_cmd: assert property (p_cmd) else $error("command read not zero");
   property p_map; s_rd ##0 avs_address > 8'h18 |-> avs_readdata == 32'h00000000; endproperty
   a_map: assert property (p_map) else $error("unmapped read not zero");
   property p_sts;
      s_rd ##0 (avs_address == 8'h04 && !busy_out) |-> avs_readdata[1] == error_flag_out;
   endproperty
   a_sts: assert property (p_sts) else $error("status error bit wrong");
endmodule

bind hexasc_top hexasc_monitor #(.DEST_WORDS(DEST_WORDS)) i_mon (
   .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .error_flag_out(error_flag_out), .busy_out(busy_out));

// ---- sim/hexasc_top_tb.sv ----
// Self-checking bench for the hex-to-ASCII converter
`timescale 1ns/1ps
module hexasc_top_tb;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, error_flag_out, busy_out;
   logic [15:0] bad [4] = '{16'h3000, 16'h0004, 16'h0040, 16'h0200};
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   hexasc_top #(.DEST_WORDS(3)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .error_flag_out(error_flag_out), .busy_out(busy_out));
   initial forever #2.5 clk_sys = ~clk_sys;
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus transfer, held until waitrequest is seen low
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= w;
      avs_read <= ~w;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) mismatches++;
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 16'h0000, q);
      chk(q, {16'h0000, e});
   endtask
   task automatic go(input logic [15:0] src, input logic [15:0] ctl);
      int n;
      n = 0;
      wr(8'h08, src);
      wr(8'h0C, ctl);
      wr(8'h00, 16'h0001);
      do begin
         @(posedge clk_sys);
         n++;
      end while (busy_out !== 1'b0 && n < 20);
      if (busy_out !== 1'b0) mismatches++;
   endtask
   function automatic logic [7:0] ch(input logic [3:0] d, input logic [3:0] p);
      logic [6:0] c;
      c = (d < 4'hA) ? 7'h30 + 7'(d) : 7'h37 + 7'(d);
      ch = {(p == 4'h1) ? ^c : (p == 4'h2) ? ~^c : 1'b0, c};
   endfunction
   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      for (int a = 0; a <= 24; a += 4) rd(8'(a), 16'h0000);
      wr(8'h40, 16'hFFFF);
      rd(8'h40, 16'h0000);
      wr(8'h10, 16'hAAAA);
      wr(8'h14, 16'h5555);
      wr(8'h18, 16'h7777);
      go(16'h1234, 16'h0121);
      rd(8'h10, 16'h33AA);
      rd(8'h14, 16'h3132);
      rd(8'h18, 16'h7777);
      chk({31'h0, error_flag_out}, 32'h0);
      go(16'hB1C2, 16'h0033);
      rd(8'h10, 16'h3242);
      rd(8'h14, 16'h3143);
      // Write issued during a run stalls; the run keeps the operands it captured
      wr(8'h08, 16'h1234);
      wr(8'h0C, 16'h0033);
      wr(8'h00, 16'h0001);
      wr(8'h08, 16'hBEEF);
      rd(8'h10, 16'h3431);
      rd(8'h14, 16'h3233);
      rd(8'h08, 16'hBEEF);
      wr(8'h10, 16'hEE00);
      for (int p = 0; p < 3; p++) begin
         for (int d = 0; d < 16; d++) begin
            go(16'(d), {4'(p), 12'h000});
            rd(8'h10, {8'hEE, ch(4'(d), 4'(p))});
         end
      end
      for (int i = 0; i < 4; i++) begin
         go(16'h1234, bad[i]);
         chk({31'h0, error_flag_out}, 32'h1);
         rd(8'h04, 16'h0002);
         rd(8'h10, 16'hEE46);
      end
      go(16'h0000, 16'h0000);
      chk({31'h0, error_flag_out}, 32'h0);
      rd(8'h10, 16'hEE30);
      stop_test();
   end
endmodule
